//--- logic/asx_alu_top.sv
// Purpose: Execution datapath for subtract, xor and nibble swap with AXI4-Lite access
// Assumes: Operations are launched by software through the control register
// Notes:   An operation takes two cycles: fetch file, then compute and write back in one
//          Busy reads back as CTRL bit 0 until the write-back edge has passed
//          Window, instruction and start writes are ignored while busy
//          Upper byte lanes are ignored for every byte-wide field except the instruction literal, which is taken from lane 2
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module asx_alu_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // Three steps: read the file, compute and write back, then idle
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_EXEC
    } asx_state_t;

    // Architectural state and the operation being run
    asx_state_t          state_r;
    asx_pkg::asx_instr_t instr_r;
    asx_pkg::asx_flags_t flags_r;
    logic [7:0]          acc_r;
    logic [6:0]          win_addr_r;

    // Bus capture registers
    logic                aw_held_r;
    logic                w_held_r;
    logic [11:0]         awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic                rd_pending_r;
    logic [11:0]         araddr_r;

    // File memory port nets
    logic [7:0] mem_rdata;
    logic       mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [6:0] mem_raddr;

    // Bus decode strobes and datapath intermediates
    logic       do_write;
    logic       go_pulse;
    logic       sw_file_we;
    logic [7:0] result;
    logic [8:0] diff;
    logic [4:0] ldiff;

    // Zero test shared by every flag-updating op
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    // Byte-lane merge for writes to byte-wide fields
    // Only lane 0 is looked at; the upper lanes cannot reach the accumulator
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        return s[0] ? d[7:0] : old;
    endfunction

    // File array; its registered read is why a fetch cycle comes before exec
    asx_file_mem #(
        .DW    (asx_pkg::DATA_W),
        .AW    (asx_pkg::FADDR_W),
        .DEPTH (asx_pkg::FILE_DEPTH)
    ) u_mem (
        .aclk  (aclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Write transaction fires once both address and data are held and no response pending
    // Waiting on a free response slot gives exactly one write effect per response
    assign do_write   = aw_held_r && w_held_r && !s_axi_bvalid;
    assign go_pulse   = do_write && (awaddr_r == asx_pkg::OFF_CTRL) && wstrb_r[0] && wdata_r[0]
                        && (state_r == ST_IDLE);
    assign sw_file_we = do_write && (awaddr_r == asx_pkg::OFF_FDATA) && wstrb_r[0]
                        && (state_r == ST_IDLE);

    // Read port follows the instruction while busy, the window otherwise
    // Switching early lets the fetch cycle absorb the one-cycle memory latency
    assign mem_raddr = (state_r == ST_IDLE) ? win_addr_r : instr_r.addr;

    // Arithmetic: carry and digit carry are the no-borrow outputs of the subtraction
    // The top bit of each difference is the borrow out of that width
    assign diff  = {1'b0, mem_rdata} - {1'b0, acc_r};
    assign ldiff = {1'b0, mem_rdata[3:0]} - {1'b0, acc_r[3:0]};

    // Result select per operation
    // Swap is the default arm so every op code yields a result
    always_comb begin
        case (instr_r.op)
            asx_pkg::OP_SUB_ACC_FROM_FILE:    result = diff[7:0];
            asx_pkg::OP_XOR_LITERAL_INTO_ACC: result = acc_r ^ instr_r.literal;
            asx_pkg::OP_XOR_ACC_WITH_FILE:    result = acc_r ^ mem_rdata;
            default:                          result = {mem_rdata[3:0], mem_rdata[7:4]};
        endcase
    end

    // File write: datapath writeback in exec, otherwise software window
    // Window writes are refused while busy, so the two sources never collide
    always_comb begin
        if (state_r == ST_EXEC) begin
            // Literal xor has no file operand and never writes the file
            mem_we    = instr_r.dest_file && (instr_r.op != asx_pkg::OP_XOR_LITERAL_INTO_ACC);
            mem_waddr = instr_r.addr;
            mem_wdata = result;
        end else begin
            mem_we    = sw_file_we;
            mem_waddr = win_addr_r;
            mem_wdata = wdata_r[7:0];
        end
    end

    // Sequencer; fetch cycle covers the registered memory read
    // Exec always falls back to idle, so launches are at least three cycles apart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE:  state_r <= go_pulse ? ST_FETCH : ST_IDLE;
                ST_FETCH: state_r <= ST_EXEC;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // Accumulator: ops write it when destination is 0; literal xor always does
    // Write back beats a software write landing in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= asx_pkg::ACC_RESET;
        end else if (state_r == ST_EXEC) begin
            // Literal xor ignores the destination bit
            if (instr_r.op == asx_pkg::OP_XOR_LITERAL_INTO_ACC || !instr_r.dest_file) begin
                acc_r <= result;
            end
        end else if (do_write && awaddr_r == asx_pkg::OFF_ACC) begin
            acc_r <= lane0(acc_r, wdata_r, wstrb_r);
        end
    end

    // Flags: swap leaves all alone, xors touch zero only
    // Software may preset the flags; a write during exec is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= '0;
        end else if (state_r == ST_EXEC) begin
            case (instr_r.op)
                asx_pkg::OP_SUB_ACC_FROM_FILE: begin
                    // Inverted borrows: set when the accumulator does not exceed the file
                    flags_r.carry            <= ~diff[8];
                    flags_r.digit_carry_flag <= ~ldiff[4];
                    flags_r.zero             <= is_zero(result);
                end
                asx_pkg::OP_NIBBLE_SWAP_FILE: flags_r <= flags_r;
                default: flags_r.zero <= is_zero(result);
            endcase
        end else if (do_write && awaddr_r == asx_pkg::OFF_STATUS && wstrb_r[0]) begin
            // Field by field, so the member order of the carrier cannot scramble them
            flags_r.carry            <= wdata_r[asx_pkg::ST_CARRY];
            flags_r.digit_carry_flag <= wdata_r[asx_pkg::ST_DIGIT_CARRY];
            flags_r.zero             <= wdata_r[asx_pkg::ST_ZERO];
        end
    end

    // Instruction and window address registers; instruction frozen while busy
    // Partial strobes update only the fields whose byte lanes are enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_r    <= '0;
            win_addr_r <= '0;
        end else if (do_write && state_r == ST_IDLE) begin
            if (awaddr_r == asx_pkg::OFF_INSTR) begin
                if (wstrb_r[0]) begin
                    instr_r.op        <= asx_pkg::asx_op_t'(wdata_r[asx_pkg::INS_OP_LSB +: 2]);
                    instr_r.dest_file <= wdata_r[asx_pkg::INS_DEST_BIT];
                end
                if (wstrb_r[1]) begin
                    instr_r.addr <= wdata_r[asx_pkg::INS_ADDR_LSB +: 7];
                end
                if (wstrb_r[2]) begin
                    instr_r.literal <= wdata_r[asx_pkg::INS_LIT_LSB +: 8];
                end
            end else if (awaddr_r == asx_pkg::OFF_FADDR && wstrb_r[0]) begin
                // Only the low seven bits address the file
                win_addr_r <= wdata_r[6:0];
            end
        end
    end

    // AXI write address and data capture, either order
    // Ready pulses for one cycle; the master holds valid until it sees it
    // Addresses are forced to word alignment, so byte offsets inside a word alias
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    // The answer stands until bready; no further write takes effect until then
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= asx_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r <= asx_pkg::OFF_FDATA) ? asx_pkg::RESP_OKAY : asx_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read: address taken, then data one cycle later so file reads see registered memory
    // Unmapped offsets answer zero data with SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            rd_pending_r  <= 1'b0;
            araddr_r      <= '0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= asx_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !rd_pending_r && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pending_r <= 1'b1;
                araddr_r     <= {s_axi_araddr[11:2], 2'b00};
            end else if (rd_pending_r) begin
                rd_pending_r <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= asx_pkg::RESP_OKAY;
                // Busy reads as one from the start edge until exec is done
                if (araddr_r == asx_pkg::OFF_CTRL) begin
                    s_axi_rdata <= {31'h0, state_r != ST_IDLE};
                end else if (araddr_r == asx_pkg::OFF_INSTR) begin
                    // Same field layout as the write side
                    s_axi_rdata <= {8'h00, instr_r.literal, 1'b0, instr_r.addr, 5'h00,
                                    instr_r.dest_file, instr_r.op};
                end else if (araddr_r == asx_pkg::OFF_ACC) begin
                    s_axi_rdata <= {24'h0, acc_r};
                end else if (araddr_r == asx_pkg::OFF_STATUS) begin
                    s_axi_rdata <= {29'h0, flags_r.zero, flags_r.digit_carry_flag, flags_r.carry};
                end else if (araddr_r == asx_pkg::OFF_FADDR) begin
                    s_axi_rdata <= {25'h0, win_addr_r};
                end else if (araddr_r == asx_pkg::OFF_FDATA) begin
                    // The window address sat on the read port through the cycle the address was taken
                    s_axi_rdata <= {24'h0, mem_rdata};
                end else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= asx_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- logic/asx_pkg.sv
// Purpose: Shared constants and types for the subtract/xor/swap execution datapath
// Assumes: One clock (aclk, 250 MHz), synchronous active-low reset
// Notes:   Register map sits behind an AXI4-Lite slave
// Contract
// - Subtract accumulator from 7-bit-addressed file register
// - Subtract sets carry and digit-carry as no-borrow
// - Destination bit 0 writes accumulator, 1 writes file
// - Literal xor always writes accumulator, zero flag only
// - Nibble swap exchanges halves, flags untouched
// - File xor goes to destination, zero flag only
package asx_pkg;

    localparam int DATA_W      = 8;
    localparam int FADDR_W     = 7;
    localparam int FILE_DEPTH  = 128;
    localparam int AXI_AW      = 12;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;  // write: start op; read: busy
    localparam logic [11:0] OFF_INSTR  = 12'h004;  // op, dest, addr, literal
    localparam logic [11:0] OFF_ACC    = 12'h008;  // working accumulator
    localparam logic [11:0] OFF_STATUS = 12'h00c;  // carry, digit carry, zero
    localparam logic [11:0] OFF_FADDR  = 12'h010;  // file window address
    localparam logic [11:0] OFF_FDATA  = 12'h014;  // file window data

    // Instruction register fields
    localparam int INS_OP_LSB   = 0;   // 2 bits
    localparam int INS_DEST_BIT = 2;
    localparam int INS_ADDR_LSB = 8;   // 7 bits
    localparam int INS_LIT_LSB  = 16;  // 8 bits

    // Status register fields
    localparam int ST_CARRY       = 0;
    localparam int ST_DIGIT_CARRY = 1;
    localparam int ST_ZERO        = 2;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_SUB_ACC_FROM_FILE,
        OP_XOR_LITERAL_INTO_ACC,
        OP_XOR_ACC_WITH_FILE,
        OP_NIBBLE_SWAP_FILE
    } asx_op_t;

    typedef struct packed {
        asx_op_t           op;
        logic              dest_file;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] literal;
    } asx_instr_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } asx_flags_t;

endpackage

//--- logic/asx_file_mem.sv
// Purpose: File register memory with one write port and registered read data
// Assumes: Single clock; read data valid one cycle after address
// Notes:   Contents are not reset, as in a real register file array
`timescale 1ns/10ps
module asx_file_mem #(
    parameter int DW    = 8,
    parameter int AW    = 7,
    parameter int DEPTH = 128
) (
    input  wire logic          aclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge aclk) begin
        rdata <= mem[raddr];
    end
endmodule

//--- dv/asx_alu_props.sv
// Purpose: Bus timing checks on the execution datapath ports
// Assumes: One clock, synchronous active-low reset
// Notes:   Arithmetic results are judged by the bench
`timescale 1ns/10ps
module asx_alu_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address taken, then the response follows within a short bound
    sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
    sequence b_soon; ##[1:4] s_axi_bvalid; endsequence
    a_write_answered: assert property (aw_take |-> b_soon) else $error("write response missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answered: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read data dropped early");
    a_no_ar_pending: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
    a_rdata_byte: assert property (s_axi_rvalid && s_axi_rresp == asx_pkg::RESP_OKAY
        |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    a_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
endmodule

//--- dv/asx_axi_master.sv
// Purpose: Register bus master standing in for the decoder side
// Assumes: One transfer of each kind at a time
// Notes:   Released address and data lines are inverted, strobes zeroed, so stale values never match
`timescale 1ns/10ps
module asx_axi_master (
    input  wire logic        aclk,
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    output logic             tmo
);
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, tmo} = '0;
    end
    // Response ready comes late at random, but is always up by the time the answer is raised
    task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        int dly;
        dly = $urandom_range(3);
        resp = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (dly == 0);
        for (n = 0; n < 64 && resp == 2'h3; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
                s_axi_wstrb <= 4'h0;
            end
            if (n + 1 == dly) s_axi_bready <= 1'b1;
            if (s_axi_bvalid && s_axi_bready) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (resp == 2'h3) tmo <= 1'b1;
    endtask
    // Read data itself is picked up by the bench monitor
    task rd(input logic [11:0] a);
        int n;
        int dly;
        logic done;
        dly = $urandom_range(3);
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (dly == 0);
        for (n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (n + 1 == dly) s_axi_rready <= 1'b1;
            if (s_axi_rvalid && s_axi_rready) begin
                done = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
        if (!done) tmo <= 1'b1;
    endtask
endmodule

//--- dv/asx_alu_top_tb.sv
// Purpose: Self-checking bench for the subtract, xor and swap datapath
// Assumes: Results are read back over the register bus
// Notes:   Expected values come from a small model kept here
`timescale 1ns/10ps
module asx_alu_top_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tmo;
    int          n_mismatch = 0;
    int          comparisons = 0;
    logic [33:0] exp_q [$];
    always #2 aclk = ~aclk;
    asx_alu_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    asx_axi_master i_mst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tmo);
    task chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] resp;
        i_mst.wr(a, d, resp);
        chk({32'h0, resp}, {32'h0, e});
    endtask
    task r(input logic [11:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        i_mst.rd(a);
    endtask
    // Each read answer is matched to the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_q.size() == 0) chk(34'h0, 34'h1); // Answer with no note queued
            else chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end
    // A stuck handshake ends the run as a failure
    always @(posedge tmo) begin
        n_mismatch++;
        close_out();
    end
    // Reset values, unmapped place, then a mix of operations
    initial begin
        int i;
        logic [1:0] op;
        logic dst;
        logic [6:0] ad;
        logic [7:0] lit, acc, fv, res;
        logic [2:0] st;
        void'($urandom(79267));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        r(asx_pkg::OFF_ACC, 34'h0);
        r(asx_pkg::OFF_STATUS, 34'h0);
        r(12'h018, {asx_pkg::RESP_SLVERR, 32'h0});
        w(12'h018, 32'hff, asx_pkg::RESP_SLVERR);
        for (i = 0; i < 48; i++) begin
            op = i < 8 ? i[1:0] : 2'($urandom);
            dst = i < 8 ? i[2] : 1'($urandom);
            ad = 7'($urandom);
            acc = 8'($urandom);
            st = 3'($urandom);
            lit = i < 4 ? acc : 8'($urandom); // Equal operands force a zero result for subtract and both xors
            fv = i < 4 ? acc : 8'($urandom);
            w(asx_pkg::OFF_FADDR, {25'h0, ad}, asx_pkg::RESP_OKAY);
            w(asx_pkg::OFF_FDATA, {24'h0, fv}, asx_pkg::RESP_OKAY);
            w(asx_pkg::OFF_ACC, {24'h0, acc}, asx_pkg::RESP_OKAY);
            w(asx_pkg::OFF_STATUS, {29'h0, st}, asx_pkg::RESP_OKAY);
            w(asx_pkg::OFF_INSTR, {8'h0, lit, 1'b0, ad, 5'h0, dst, op}, asx_pkg::RESP_OKAY);
            w(asx_pkg::OFF_CTRL, 32'h1, asx_pkg::RESP_OKAY);
            case (op)
                2'h0: begin
                    res = fv - acc;
                    st = {res == 8'h0, acc[3:0] <= fv[3:0], acc <= fv};
                end
                2'h1: begin
                    res = acc ^ lit;
                    st[2] = res == 8'h0;
                end
                2'h2: begin
                    res = acc ^ fv;
                    st[2] = res == 8'h0;
                end
                default: res = {fv[3:0], fv[7:4]};
            endcase
            if (op == 2'h1 || !dst) acc = res;
            else fv = res;
            r(asx_pkg::OFF_CTRL, 34'h0);
            r(asx_pkg::OFF_ACC, {26'h0, acc});
            r(asx_pkg::OFF_STATUS, {31'h0, st});
            r(asx_pkg::OFF_FDATA, {26'h0, fv});
        end
        @(posedge aclk);
        chk(34'(exp_q.size()), 34'h0);
        close_out();
    end
endmodule
bind asx_alu_top asx_alu_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
